// >>> include/cpcr_consts.svh
// Register indices, field positions, reset values and timing counts of the protection config bank.
`ifndef CPCR_CONSTS_SVH
`define CPCR_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define CPCR_IDX_RC_THRESH 8'hC6
`define CPCR_IDX_KS_PRETRIG 8'hC7
`define CPCR_IDX_FAST_OFF 8'hC8
`define CPCR_IDX_PG_POL 8'hD0
`define CPCR_IDX_FAST_OCP 8'hD1
`define CPCR_IDX_DELAY_UNIT 8'hD2
`define CPCR_IDX_SCALE_MON 8'hD3
`define CPCR_IDX_IRQ_STATUS 8'hE0
`define CPCR_IDX_IRQ_MASK 8'hE1

// Fast over-current word fields.
`define CPCR_OCP_SAMPLES_HI 12
`define CPCR_OCP_SAMPLES_LO 8
`define CPCR_OCP_ENABLE_BIT 7
`define CPCR_OCP_LEVEL_HI 6

// Lowest bit of each 2-bit delay-unit field.
`define CPCR_UNIT_VOUT_LO 6
`define CPCR_UNIT_VIN_LO 4
`define CPCR_UNIT_IOUT_LO 2
`define CPCR_UNIT_TEMP_LO 0

// Milliseconds per unit for each delay-unit code.
`define CPCR_UNIT_MS_0 10'h001
`define CPCR_UNIT_MS_1 10'h00A
`define CPCR_UNIT_MS_2 10'h064
`define CPCR_UNIT_MS_3 10'h3E8

// Reset values.
`define CPCR_RST_BYTE 8'h00
`define CPCR_RST_WORD 16'h0000
`define CPCR_RST_IRQ 7'h00

// Timing, in nanoseconds, and the cycle counts derived from it.
`define CPCR_CLK_PERIOD_NS 50
`define CPCR_KS_BASE_NS 20000
`define CPCR_KS_STEP_NS 450
`define CPCR_MS_NS 1000000
`define CPCR_KS_BASE_CYC (`CPCR_KS_BASE_NS / `CPCR_CLK_PERIOD_NS)
`define CPCR_KS_STEP_CYC (`CPCR_KS_STEP_NS / `CPCR_CLK_PERIOD_NS)
`define CPCR_MS_CYC (`CPCR_MS_NS / `CPCR_CLK_PERIOD_NS)

`endif

// >>> include/cpcr_pkg.sv
// Types shared by the protection config bank modules.
package cpcr_pkg;
  // Delay-unit codes.
  typedef enum logic [1:0] {
    CPCR_UNIT_1MS = 2'h0,
    CPCR_UNIT_10MS = 2'h1,
    CPCR_UNIT_100MS = 2'h2,
    CPCR_UNIT_1S = 2'h3
  } cpcr_unit_e;

  // Two-state sequencer used by the delay timers and the kickstart timer.
  typedef enum logic {
    CPCR_IDLE = 1'b0,
    CPCR_COUNT = 1'b1
  } cpcr_seq_e;
endpackage

// >>> hdl/cpcr_ocp_detect.sv
// Fast over-current detector: consecutive-sample counter against a trip level.
`timescale 1ns/1ps
`include "cpcr_consts.svh"
module cpcr_ocp_detect import cpcr_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings.
  input wire logic enable,
  input wire logic [6:0] level,
  input wire logic [4:0] samples,
  // Current samples.
  input wire logic [6:0] sample,
  input wire logic sample_valid,
  // Trip level.
  output logic trip
);
  logic [4:0] count_reg; // Consecutive samples above the level.
  logic [4:0] count_next;
  logic [4:0] need; // Samples needed; zero is taken as one.
  logic trip_reg;

  // Next count: grow on a sample above the level, restart on one at or below it.
  always_comb begin
    need = (samples == 5'h00) ? 5'h01 : samples;
    count_next = count_reg;
    if (!enable) begin
      count_next = 5'h00;
    end else if (sample_valid) begin
      if (sample > level) begin
        count_next = (count_reg == 5'h1F) ? count_reg : count_reg + 5'h01;
      end else begin
        count_next = 5'h00;
      end
    end
  end

  // Counter and trip flag; disabling the protection drops the trip at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 5'h00;
      trip_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      trip_reg <= enable && (count_next >= need);
    end
  end

  assign trip = trip_reg;
endmodule

// >>> hdl/cpcr_fault_timer.sv
// Fault retry/delay timer: count times the selected time base.
`timescale 1ns/1ps
`include "cpcr_consts.svh"
module cpcr_fault_timer import cpcr_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // One-millisecond tick from the shared prescaler.
  input wire logic ms_tick,
  // Start request with its count and time base.
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [1:0] unit_sel,
  // End of the delay.
  output logic done
);
  cpcr_seq_e state_reg;
  logic [7:0] remain_reg; // Units still to run.
  logic [9:0] sub_reg; // Milliseconds elapsed inside the current unit.
  logic [9:0] unit_ms_reg; // Milliseconds per unit, latched at start.
  logic done_reg;
  logic [9:0] unit_ms;

  // Time base of the requested unit code.
  always_comb begin
    unique case (cpcr_unit_e'(unit_sel))
      CPCR_UNIT_1MS: unit_ms = `CPCR_UNIT_MS_0;
      CPCR_UNIT_10MS: unit_ms = `CPCR_UNIT_MS_1;
      CPCR_UNIT_100MS: unit_ms = `CPCR_UNIT_MS_2;
      CPCR_UNIT_1S: unit_ms = `CPCR_UNIT_MS_3;
    endcase
  end

  // Count units down; a start while running is ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CPCR_IDLE;
      remain_reg <= 8'h00;
      sub_reg <= 10'h000;
      unit_ms_reg <= `CPCR_UNIT_MS_0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        CPCR_IDLE: begin
          if (start) begin
            remain_reg <= count;
            unit_ms_reg <= unit_ms;
            sub_reg <= 10'h000;
            state_reg <= CPCR_COUNT;
          end
        end
        CPCR_COUNT: begin
          if (remain_reg == 8'h00) begin
            done_reg <= 1'b1;
            state_reg <= CPCR_IDLE;
          end else if (ms_tick) begin
            if (sub_reg == unit_ms_reg - 10'h001) begin
              sub_reg <= 10'h000;
              remain_reg <= remain_reg - 8'h01;
            end else begin
              sub_reg <= sub_reg + 10'h001;
            end
          end
        end
      endcase
    end
  end

  assign done = done_reg;
endmodule

// >>> hdl/cpcr_top.sv
// Protection configuration register bank with its APB slave and the logic it steers.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "cpcr_consts.svh"
module cpcr_top import cpcr_pkg::*; #(
  // Clock cycles in one millisecond; shorten in simulation.
  parameter int unsigned MS_CYCLES = `CPCR_MS_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Remote control.
  input wire logic [7:0] remote_control_sense_input,
  output logic remote_control_trigger,
  // Kickstart.
  input wire logic kickstart_request,
  output logic kickstart_fire,
  // Fast input-off.
  input wire logic [7:0] input_voltage_sample,
  input wire logic [7:0] input_off_threshold,
  output logic fast_input_off,
  // Power good.
  input wire logic power_good_status,
  output logic power_good_pin,
  // Fast over-current.
  input wire logic [6:0] current_sample,
  input wire logic current_sample_valid,
  output logic fast_ocp_trip,
  // Fault delays; index 3 vout, 2 vin, 1 iout, 0 temperature.
  input wire logic [3:0] fault_start,
  input wire logic [7:0] fault_count_vout,
  input wire logic [7:0] fault_count_vin,
  input wire logic [7:0] fault_count_iout,
  input wire logic [7:0] fault_count_temp,
  output logic [3:0] fault_delay_done,
  // Input-scale trim values.
  input wire logic [15:0] trimmed_offset_on,
  input wire logic [15:0] trimmed_scale_off,
  // Interrupt.
  output logic irq
);
  // Configuration registers.
  logic [7:0] rc_thresh_reg; // Remote control threshold.
  logic [7:0] ks_pretrig_reg; // Kickstart pre-trigger setting.
  logic [7:0] fast_off_reg; // Fast input-off offset.
  logic [7:0] pg_pol_reg; // Power good polarity.
  logic [15:0] fast_ocp_reg; // Fast over-current word.
  logic [7:0] delay_unit_reg; // Delay unit fields.
  logic [6:0] irq_status_reg; // Sticky event bits.
  logic [6:0] irq_mask_reg; // One enables the matching status bit.

  // APB answer registers.
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // Block outputs held in flops.
  logic rc_trig_reg;
  logic fast_off_trip_reg;
  logic pg_pin_reg;
  logic irq_reg;
  logic ocp_trip_d_reg; // Previous trip level, for edge detection.

  // Kickstart timer.
  cpcr_seq_e ks_state_reg;
  logic [11:0] ks_cnt_reg;
  logic ks_fire_reg;

  // Millisecond prescaler.
  logic [14:0] ms_cnt_reg;
  logic ms_tick_reg;

  // Decode and read-back.
  logic access;
  logic complete;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rd_data;
  logic ocp_trip;
  logic [3:0] timer_done;
  logic [6:0] events;
  logic [8:0] fast_off_level;
  logic [11:0] ks_delay;
  logic [7:0] fault_count [4];

  // An access phase completes at the edge where our pready is high.
  assign access = psel && penable;
  assign complete = access && pready_reg;
  assign idx = paddr[9:2];

  // Address decode and read multiplexer.
  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h00000000;
    unique case (idx)
      `CPCR_IDX_RC_THRESH: rd_data = {24'h000000, rc_thresh_reg};
      `CPCR_IDX_KS_PRETRIG: rd_data = {24'h000000, ks_pretrig_reg};
      `CPCR_IDX_FAST_OFF: rd_data = {24'h000000, fast_off_reg};
      `CPCR_IDX_PG_POL: rd_data = {24'h000000, pg_pol_reg};
      `CPCR_IDX_FAST_OCP: rd_data = {16'h0000, fast_ocp_reg};
      `CPCR_IDX_DELAY_UNIT: rd_data = {24'h000000, delay_unit_reg};
      `CPCR_IDX_SCALE_MON: rd_data = {trimmed_offset_on, trimmed_scale_off};
      `CPCR_IDX_IRQ_STATUS: rd_data = {25'h0000000, irq_status_reg};
      `CPCR_IDX_IRQ_MASK: rd_data = {25'h0000000, irq_mask_reg};
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle, so read data come from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_data;
        pslverr_reg <= !mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Configuration writes; the monitor is read-only and ignores writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_thresh_reg <= `CPCR_RST_BYTE;
      ks_pretrig_reg <= `CPCR_RST_BYTE;
      fast_off_reg <= `CPCR_RST_BYTE;
      pg_pol_reg <= `CPCR_RST_BYTE;
      fast_ocp_reg <= `CPCR_RST_WORD;
      delay_unit_reg <= `CPCR_RST_BYTE;
      irq_mask_reg <= `CPCR_RST_IRQ;
    end else if (complete && pwrite) begin
      unique case (idx)
        `CPCR_IDX_RC_THRESH: rc_thresh_reg <= pwdata[7:0];
        `CPCR_IDX_KS_PRETRIG: ks_pretrig_reg <= pwdata[7:0];
        `CPCR_IDX_FAST_OFF: fast_off_reg <= pwdata[7:0];
        `CPCR_IDX_PG_POL: pg_pol_reg <= pwdata[7:0];
        `CPCR_IDX_FAST_OCP: fast_ocp_reg <= pwdata[15:0];
        `CPCR_IDX_DELAY_UNIT: delay_unit_reg <= pwdata[7:0];
        `CPCR_IDX_IRQ_MASK: irq_mask_reg <= pwdata[6:0];
        default: begin
          // Status is handled by its own process; other addresses ignore writes.
        end
      endcase
    end
  end

  // Remote control trips once the sensed level reaches the threshold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_trig_reg <= 1'b0;
    end else begin
      rc_trig_reg <= remote_control_sense_input >= rc_thresh_reg;
    end
  end

  // Fast input-off level is the input-off threshold raised by the offset.
  // A ninth bit keeps the sum from wrapping near full scale.
  assign fast_off_level = {1'b0, input_off_threshold} + {1'b0, fast_off_reg};

  // Shut-down request while the input sits below the raised level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_off_trip_reg <= 1'b0;
    end else begin
      fast_off_trip_reg <= {1'b0, input_voltage_sample} < fast_off_level;
    end
  end

  // Power good pin: only bit 0 of the polarity register matters.
  // Codes other than 0x00 and 0x01 are undefined; they follow bit 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_pin_reg <= 1'b1;
    end else begin
      pg_pin_reg <= pg_pol_reg[0] ? power_good_status : !power_good_status;
    end
  end

  // Kickstart delay in cycles: base plus one step per unit of the setting.
  assign ks_delay = 12'(`CPCR_KS_BASE_CYC) + 12'(ks_pretrig_reg) * 12'(`CPCR_KS_STEP_CYC);

  // Kickstart timer: fire pulses ks_delay cycles after the request.
  // A request during a running delay is ignored rather than restarting it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ks_state_reg <= CPCR_IDLE;
      ks_cnt_reg <= 12'h000;
      ks_fire_reg <= 1'b0;
    end else begin
      ks_fire_reg <= 1'b0;
      unique case (ks_state_reg)
        CPCR_IDLE: begin
          if (kickstart_request) begin
            ks_cnt_reg <= ks_delay;
            ks_state_reg <= CPCR_COUNT;
          end
        end
        CPCR_COUNT: begin
          if (ks_cnt_reg == 12'h001) begin
            ks_fire_reg <= 1'b1;
            ks_state_reg <= CPCR_IDLE;
          end else begin
            ks_cnt_reg <= ks_cnt_reg - 12'h001;
          end
        end
      endcase
    end
  end

  // Fast over-current detector on the configured word.
  cpcr_ocp_detect u_ocp (
    .pclk(pclk),
    .presetn(presetn),
    .enable(fast_ocp_reg[`CPCR_OCP_ENABLE_BIT]),
    .level(fast_ocp_reg[`CPCR_OCP_LEVEL_HI:0]),
    .samples(fast_ocp_reg[`CPCR_OCP_SAMPLES_HI:`CPCR_OCP_SAMPLES_LO]),
    .sample(current_sample),
    .sample_valid(current_sample_valid),
    .trip(ocp_trip)
  );

  // Millisecond prescaler shared by the four delay timers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= 15'h0000;
      ms_tick_reg <= 1'b0;
    end else begin
      if (ms_cnt_reg == 15'(MS_CYCLES - 1)) begin
        ms_cnt_reg <= 15'h0000;
        ms_tick_reg <= 1'b1;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 15'h0001;
        ms_tick_reg <= 1'b0;
      end
    end
  end

  // Counts from the fault response settings, by category.
  assign fault_count[0] = fault_count_temp;
  assign fault_count[1] = fault_count_iout;
  assign fault_count[2] = fault_count_vin;
  assign fault_count[3] = fault_count_vout;

  // One timer per category; field i of the unit register sits at bits 2i+1:2i.
  for (genvar i = 0; i < 4; i++) begin : g_timer
    cpcr_fault_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick_reg),
      .start(fault_start[i]),
      .count(fault_count[i]),
      .unit_sel(delay_unit_reg[2 * i + 1 -: 2]),
      .done(timer_done[i])
    );
  end

  // Events: remote trigger rise, fast-off rise, over-current rise, four delay ends.
  assign events = {timer_done, ocp_trip && !ocp_trip_d_reg,
                   (({1'b0, input_voltage_sample} < fast_off_level) && !fast_off_trip_reg),
                   ((remote_control_sense_input >= rc_thresh_reg) && !rc_trig_reg)};

  // Trip history for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocp_trip_d_reg <= 1'b0;
    end else begin
      ocp_trip_d_reg <= ocp_trip;
    end
  end

  // Sticky status, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= `CPCR_RST_IRQ;
    end else if (complete && pwrite && (idx == `CPCR_IDX_IRQ_STATUS)) begin
      irq_status_reg <= (irq_status_reg & ~pwdata[6:0]) | events;
    end else begin
      irq_status_reg <= irq_status_reg | events;
    end
  end

  // Level interrupt, one cycle behind the status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Output wiring, all from flops.
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign remote_control_trigger = rc_trig_reg;
  assign kickstart_fire = ks_fire_reg;
  assign fast_input_off = fast_off_trip_reg;
  assign power_good_pin = pg_pin_reg;
  assign fast_ocp_trip = ocp_trip;
  assign fault_delay_done = timer_done;
  assign irq = irq_reg;
endmodule

// >>> testbench/cpcr_monitor.sv
// Port-level assertion checker for the protection config bank, bound to its top.
`timescale 1ns/1ps
`include "cpcr_consts.svh"
module cpcr_monitor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Event outputs.
  input wire logic kickstart_fire,
  input wire logic current_sample_valid,
  input wire logic fast_ocp_trip,
  input wire logic [3:0] fault_delay_done,
  // Trim values shown by the monitor word.
  input wire logic [15:0] trimmed_offset_on,
  input wire logic [15:0] trimmed_scale_off
);
  // Decoded map; any other word must be refused, so a missing entry shows as an error.
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr[9:2] inside {`CPCR_IDX_RC_THRESH, `CPCR_IDX_KS_PRETRIG,
    `CPCR_IDX_FAST_OFF, `CPCR_IDX_PG_POL, `CPCR_IDX_FAST_OCP, `CPCR_IDX_DELAY_UNIT, `CPCR_IDX_SCALE_MON,
    `CPCR_IDX_IRQ_STATUS, `CPCR_IDX_IRQ_MASK});

  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_after_access_a: assert property ((psel && penable && !pready) |=> pready)
    else $error("pready missing one cycle into the access");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ready_in_access_a: assert property (pready |-> (psel && penable))
    else $error("pready outside an access phase");
  unmapped_error_a: assert property (pready |-> (pslverr == !mapped))
    else $error("pslverr does not match the address map");
  error_read_zero_a: assert property ((pready && pslverr && !pwrite) |-> (prdata == 32'h0))
    else $error("refused read returned data");
  monitor_read_a: assert property ((pready && !pwrite && paddr == 10'h34C) |->
    (prdata == {trimmed_offset_on, trimmed_scale_off})) else $error("monitor word mismatch");
  kick_pulse_a: assert property (kickstart_fire |=> !kickstart_fire)
    else $error("kickstart fire wider than one cycle");
  done_pulse_a: assert property ((|fault_delay_done) |=> ((fault_delay_done & $past(fault_delay_done)) == 4'h0))
    else $error("delay done wider than one cycle");
  ocp_cause_a: assert property ($rose(fast_ocp_trip) |-> $past(current_sample_valid))
    else $error("over-current trip without a sample");
endmodule

bind cpcr_top cpcr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .kickstart_fire(kickstart_fire), .current_sample_valid(current_sample_valid),
  .fast_ocp_trip(fast_ocp_trip), .fault_delay_done(fault_delay_done),
  .trimmed_offset_on(trimmed_offset_on), .trimmed_scale_off(trimmed_scale_off));

// >>> testbench/tb_top.sv
// Self-checking bench for the protection config bank.
`timescale 1ns/1ps
`include "cpcr_consts.svh"
module tb_top;
  import cpcr_pkg::*;
  // Shortened millisecond, so the one-second unit still fits the run.
  localparam int unsigned MS = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rc_sense, vin_sample, vin_off;
  logic ks_req, ks_fire, rc_trig, fast_off, pg_status, pg_pin, cur_valid, ocp_trip, irq;
  logic [6:0] cur_sample;
  logic [3:0] f_start, f_done;
  logic [7:0] f_cnt [4]; // Index 3 vout, 2 vin, 1 iout, 0 temperature.
  int failures, checks;

  cpcr_top #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .remote_control_sense_input(rc_sense), .remote_control_trigger(rc_trig), .kickstart_request(ks_req),
    .kickstart_fire(ks_fire), .input_voltage_sample(vin_sample), .input_off_threshold(vin_off),
    .fast_input_off(fast_off), .power_good_status(pg_status), .power_good_pin(pg_pin),
    .current_sample(cur_sample), .current_sample_valid(cur_valid), .fast_ocp_trip(ocp_trip),
    .fault_start(f_start), .fault_count_vout(f_cnt[3]), .fault_count_vin(f_cnt[2]),
    .fault_count_iout(f_cnt[1]), .fault_count_temp(f_cnt[0]), .fault_delay_done(f_done),
    .trimmed_offset_on(16'h1234), .trimmed_scale_off(16'hABCD), .irq(irq));

  // Free-running 50 ns clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Waits a number of whole cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer by register index; read data and error land in rd and err.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until pready is seen high at an edge.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset values, byte-wide read/write, read-only monitor and a refused address.
  task automatic t_regs;
    logic [7:0] idx [6];
    idx = '{`CPCR_IDX_RC_THRESH, `CPCR_IDX_KS_PRETRIG, `CPCR_IDX_FAST_OFF, `CPCR_IDX_PG_POL,
      `CPCR_IDX_DELAY_UNIT, `CPCR_IDX_IRQ_MASK};
    foreach (idx[i]) begin
      apb(1'b0, idx[i], 32'h0);
      check(rd, 32'h0);
      apb(1'b1, idx[i], 32'hFFFFFF5A);
      apb(1'b0, idx[i], 32'h0);
      check(rd, 32'h0000005A);
      apb(1'b1, idx[i], 32'h0);
    end
    apb(1'b1, `CPCR_IDX_FAST_OCP, 32'h00001FFF);
    apb(1'b0, `CPCR_IDX_FAST_OCP, 32'h0);
    check(rd, 32'h00001FFF);
    apb(1'b1, `CPCR_IDX_SCALE_MON, 32'h55555555);
    check(err, 1'b0);
    apb(1'b0, `CPCR_IDX_SCALE_MON, 32'h0);
    check(rd, 32'h1234ABCD);
    apb(1'b0, 8'hFF, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask

  // Threshold boundary, masked and unmasked interrupt, write-one-to-clear.
  task automatic t_rc_irq;
    apb(1'b1, `CPCR_IDX_FAST_OCP, 32'h0);
    apb(1'b1, `CPCR_IDX_RC_THRESH, 32'h80);
    // Earlier scenarios leave events behind, so start from a cleared status.
    apb(1'b1, `CPCR_IDX_IRQ_STATUS, 32'h7F);
    apb(1'b0, `CPCR_IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    rc_sense <= 8'h7F;
    cyc(3);
    check(rc_trig, 1'b0);
    rc_sense <= 8'h80;
    cyc(3);
    check(rc_trig, 1'b1);
    check(irq, 1'b0);
    apb(1'b0, `CPCR_IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, `CPCR_IDX_IRQ_MASK, 32'h1);
    cyc(2);
    check(irq, 1'b1);
    apb(1'b1, `CPCR_IDX_IRQ_STATUS, 32'h1);
    cyc(2);
    check(irq, 1'b0);
  endtask

  // Fast input-off just below and exactly at threshold plus offset.
  task automatic t_fast_off;
    apb(1'b1, `CPCR_IDX_FAST_OFF, 32'h10);
    vin_off <= 8'h40;
    vin_sample <= 8'h4F;
    cyc(3);
    check(fast_off, 1'b1);
    vin_sample <= 8'h50;
    cyc(3);
    check(fast_off, 1'b0);
  endtask

  // Both polarity codes against both states of the internal good signal.
  task automatic t_pg;
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `CPCR_IDX_PG_POL, p);
      for (int s = 0; s < 2; s++) begin
        pg_status <= s[0];
        cyc(3);
        check(pg_pin, p[0] ? s[0] : !s[0]);
      end
    end
  endtask

  // Feeds a run of back-to-back qualified samples.
  task automatic feed(input logic [6:0] v [$]);
    foreach (v[i]) begin
      @(posedge pclk);
      cur_sample <= v[i];
      cur_valid <= 1'b1;
    end
    @(posedge pclk);
    cur_valid <= 1'b0;
    cyc(2);
  endtask

  // Level 0x20, three samples: an equal sample breaks the run; disable blocks any trip.
  task automatic t_ocp;
    apb(1'b1, `CPCR_IDX_FAST_OCP, 32'h000003A0);
    feed('{7'h21, 7'h21, 7'h20, 7'h21, 7'h21});
    check(ocp_trip, 1'b0);
    feed('{7'h21, 7'h21, 7'h21});
    check(ocp_trip, 1'b1);
    feed('{7'h20});
    check(ocp_trip, 1'b0);
    apb(1'b1, `CPCR_IDX_FAST_OCP, 32'h00000320);
    feed('{7'h7F, 7'h7F, 7'h7F, 7'h7F});
    check(ocp_trip, 1'b0);
  endtask

  // Setting 2 gives 20 us plus two 450 ns steps: 418 cycles, within one cycle of phase.
  task automatic t_ks;
    int n;
    apb(1'b1, `CPCR_IDX_KS_PRETRIG, 32'h2);
    @(posedge pclk);
    ks_req <= 1'b1;
    @(posedge pclk);
    ks_req <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ks_fire !== 1'b1 && n < 600);
    check(n >= 417 && n <= 419, 1'b1);
  endtask

  // Each field gets its own unit code, so a swapped field or code shows in the timing.
  task automatic t_fault;
    int ex [4];
    int t [4];
    ex = '{5 * 1, 3 * 10, 1 * 100, 1 * 1000};
    t = '{0, 0, 0, 0};
    f_cnt <= '{8'd5, 8'd3, 8'd1, 8'd1};
    apb(1'b1, `CPCR_IDX_DELAY_UNIT, 32'hE4);
    @(posedge pclk);
    f_start <= 4'hF;
    @(posedge pclk);
    f_start <= 4'h0;
    for (int c = 1; c < 22000; c++) begin
      @(posedge pclk);
      foreach (t[i]) begin
        if (f_done[i] === 1'b1 && t[i] == 0) begin
          t[i] = c;
        end
      end
    end
    // A delay may start anywhere within a millisecond tick, hence the tolerance.
    foreach (t[i]) begin
      check(t[i] >= ex[i] * MS - MS && t[i] <= ex[i] * MS + 3, 1'b1);
    end
    apb(1'b0, `CPCR_IDX_IRQ_STATUS, 32'h0);
    check(rd[6:3], 4'hF);
  endtask

  // Mid-run reset: the pin shows not-good and the mask returns to zero.
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(3);
    check(pg_pin, 1'b1);
    check(irq, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, `CPCR_IDX_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
  endtask

  // Main sequence: every input set at time zero, ten cycles of reset.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    rc_sense = 8'h00;
    vin_sample = 8'h00;
    vin_off = 8'h00;
    ks_req = 1'b0;
    pg_status = 1'b0;
    cur_sample = 7'h00;
    cur_valid = 1'b0;
    f_start = 4'h0;
    f_cnt = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rc_irq();
    t_fast_off();
    t_pg();
    t_ocp();
    t_ks();
    t_fault();
    t_reset();
    stop_test();
  end
endmodule
